// ===== design/iopt_pkg.sv
// iopt_pkg: constants and types shared by the io channel transfer block
// assumes a single 10 MHz core clock; no software register map
package iopt_pkg;
  localparam int CH_N       = 14;     // channels per direction
  localparam int CHW        = 4;      // channel number width
  localparam int W          = 30;     // word width
  localparam int HW         = 15;     // half word, also address width
  localparam int MEM_WORDS  = 32768;  // core memory size
  localparam int GRP_N      = 3;      // general driver groups
  localparam int GRP_CH     = 4;      // channels served per driver group
  localparam int PEER_N     = 2;      // peer channels are 0 and 1
  localparam int FIFO_DEPTH = 8;      // output word buffer depth
  localparam int FIFO_W     = CHW + W;
  localparam int CLK_NS     = 100;    // core clock period
  localparam int MEM_CYCLE_NS   = 8000;   // read/restore cycle time
  localparam int MEM_CYCLE_CLKS = (MEM_CYCLE_NS + CLK_NS - 1) / CLK_NS;
  localparam logic [6:0] CYC_FIRST = 7'h00;
  localparam logic [6:0] CYC_WB    = 7'h02;  // control word write back
  localparam logic [6:0] CYC_LAST  = 7'(MEM_CYCLE_CLKS - 1);
  localparam logic [HW-1:0] CW_IN_BASE  = 15'h7FC0;  // input control words
  localparam logic [HW-1:0] CW_OUT_BASE = 15'h7FD0;  // output control words
  localparam logic [CH_N-1:0] CH_NONE = 14'h0000;

  // memory cycle sequencer
  typedef enum logic [3:0] {
    IOPT_IDLE    = 4'h1,
    IOPT_FETCH   = 4'h2,
    IOPT_MOVE    = 4'h4,
    IOPT_RESTORE = 4'h8
  } iopt_state_t;
endpackage

// ===== design/iopt_arb.sv
// iopt_arb: fixed priority picker, highest numbered request wins
// assumes requests come from logic on the same clock
`timescale 1ns/100ps
module iopt_arb
  import iopt_pkg::*;
#(
  parameter int N = CH_N
) (
  input  wire logic [N-1:0]   req,
  output logic      [N-1:0]   gnt,
  output logic      [CHW-1:0] idx,
  output logic                any
);
  logic [N:0] above;  // above[i]: a request at bit i or higher

  // ripple from the top so channel 0 and 1 lose to any request above them
  assign above[N] = 1'b0;
  genvar i;
  generate
    for (i = N - 1; i >= 0; i--) begin : g_pri
      assign above[i] = above[i+1] | req[i];
      assign gnt[i]   = req[i] & ~above[i+1];
    end
  endgenerate
  assign any = above[0];

  // encode the single grant bit
  always_comb begin
    idx = '0;
    for (int k = 0; k < N; k++) begin
      if (gnt[k]) begin
        idx = CHW'(k);
      end
    end
  end
endmodule // iopt_arb

// ===== design/iopt_fifo.sv
// iopt_fifo: small word buffer with valid/ready on both sides
// assumes depth is a power of two; same clock on both sides
`timescale 1ns/100ps
module iopt_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 8
) (
  input  wire logic             core_clk,
  input  wire logic             resetn,
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  out_valid,
  input  wire logic             out_ready,
  output logic      [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] buf_q [DEPTH];
  logic [AW:0]      wr_ptr;
  logic [AW:0]      rd_ptr;
  wire              push = in_valid & in_ready;
  wire              pop  = out_valid & out_ready;

  // extra pointer bit tells full from empty
  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = buf_q[rd_ptr[AW-1:0]];

  // pointers
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= wr_ptr + (AW+1)'(push);
      rd_ptr <= rd_ptr + (AW+1)'(pop);
    end
  end

  // storage carries no reset, only valid entries are ever read
  always_ff @(posedge core_clk) begin
    if (push) begin
      buf_q[wr_ptr[AW-1:0]] <= in_data;
    end
  end
endmodule // iopt_fifo

// ===== design/iopt_core.sv
// iopt_core: channel priority and access logic with core memory
// assumes channel pins are asynchronous; program ports share core_clk
//
// Summary of operation
// - general register sends memory words to non-peers
// - three 30-bit driver groups, four channels each
// - peer register drives channels 0 and 1
// - outputs 0..13, highest number served first
// - inputs, highest requesting channel granted first
// - channels 0 and 1 rank lowest within each direction
// - input words go straight into memory
// - request and acknowledge exchanged per word
// - busy test refuses start on active channel
// - one control word per channel gives addresses
// - control word signal deactivates finished channel
// - 32768 words of 30 bits, two halves
// - destructive read, 8 us read/restore cycle
// - restore may add one to either half
// - equal halves raise transfer end
// - channel set up by request before data
// - finished monitored channel raises interrupt, high first
`timescale 1ns/100ps
module iopt_core
  import iopt_pkg::*;
(
  input  wire logic                core_clk,
  input  wire logic                resetn,
  input  wire logic [CH_N-1:0]     in_req,
  input  wire logic [CH_N*W-1:0]   in_data,
  output logic      [CH_N-1:0]     in_ack,
  input  wire logic [CH_N-1:0]     out_req,
  output logic      [CH_N-1:0]     out_ack,
  output logic      [GRP_N*W-1:0]  gen_drv,
  output logic      [W-1:0]        peer_drv,
  input  wire logic                start_en,
  input  wire logic                start_out,
  input  wire logic [CHW-1:0]      start_ch,
  input  wire logic                start_mon,
  input  wire logic                start_inc_up,
  output logic                     start_ok,
  output logic                     start_refused,
  output logic      [CH_N-1:0]     in_busy,
  output logic      [CH_N-1:0]     out_busy,
  input  wire logic                prog_en,
  input  wire logic                prog_we,
  input  wire logic [HW-1:0]       prog_addr,
  input  wire logic [W-1:0]        prog_wdata,
  output logic      [W-1:0]        prog_rdata,
  output logic                     prog_done,
  output logic                     int_req,
  output logic                     int_out,
  output logic      [CHW-1:0]      int_ch,
  input  wire logic                int_clr,
  input  wire logic                int_clr_out,
  input  wire logic [CHW-1:0]      int_clr_ch
);
  logic [W-1:0]      mem [MEM_WORDS];  // core store
  logic [CH_N-1:0]   in_req_m, in_req_s, out_req_m, out_req_s;
  logic [CH_N*W-1:0] in_dat_m, in_dat_s;
  logic [CH_N-1:0]   in_mon, out_mon, in_incu, out_incu;
  logic [CH_N-1:0]   out_pend, in_term, out_term;
  iopt_state_t       state;
  logic [6:0]        cyc;
  logic [CHW-1:0]    cur_ch;
  logic              cur_out;
  logic [W-1:0]      z;  // memory data register

  // first stage of each synchroniser feeds only the second
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_req_m  <= '0;
      in_req_s  <= '0;
      out_req_m <= '0;
      out_req_s <= '0;
      in_dat_m  <= '0;
      in_dat_s  <= '0;
    end else begin
      in_req_m  <= in_req;
      in_req_s  <= in_req_m;
      out_req_m <= out_req;
      out_req_s <= out_req_m;
      in_dat_m  <= in_data;
      in_dat_s  <= in_dat_m;
    end
  end

  // eligibility: word asked for by the device, channel live, no word open
  wire [CH_N-1:0] in_elig  = in_req_s & in_busy & ~in_ack;
  wire [CH_N-1:0] out_elig = out_req_s & out_busy & ~out_pend & ~out_ack;
  wire [CH_N-1:0] in_gnt, out_gnt, ti_gnt, to_gnt;
  wire [CHW-1:0]  in_idx, out_idx, ti_idx, to_idx;
  wire            in_any, out_any, ti_any, to_any;
  wire            f_in_ready, f_valid, f_ready;
  wire [FIFO_W-1:0] f_head;

  // highest number wins, so peer channels 0 and 1 come last
  iopt_arb #(.N(CH_N)) u_arb_in (
    .req (in_elig),
    .gnt (in_gnt),
    .idx (in_idx),
    .any (in_any)
  );
  iopt_arb #(.N(CH_N)) u_arb_out (
    .req (out_elig),
    .gnt (out_gnt),
    .idx (out_idx),
    .any (out_any)
  );
  iopt_arb #(.N(CH_N)) u_arb_ti (
    .req (in_term),
    .gnt (ti_gnt),
    .idx (ti_idx),
    .any (ti_any)
  );
  iopt_arb #(.N(CH_N)) u_arb_to (
    .req (out_term),
    .gnt (to_gnt),
    .idx (to_idx),
    .any (to_any)
  );

  // one channel per memory cycle; inputs before outputs since an input
  // word has nowhere to wait; a full buffer holds outputs back
  wire idle    = state == IOPT_IDLE;
  wire go_in   = in_any;
  wire go      = idle & ~prog_en & (in_any | (out_any & f_in_ready));
  wire [CHW-1:0] go_ch = go_in ? in_idx : out_idx;

  // current channel's control word and its fields
  wire [HW-1:0] cw_addr = (cur_out ? CW_OUT_BASE : CW_IN_BASE) + HW'(cur_ch);
  wire          cur_incu = cur_out ? out_incu[cur_ch] : in_incu[cur_ch];
  wire          cur_mon  = cur_out ? out_mon[cur_ch] : in_mon[cur_ch];
  wire [HW-1:0] z_up = z[W-1:HW];
  wire [HW-1:0] z_lo = z[HW-1:0];
  wire [HW-1:0] data_addr = cur_incu ? z_up : z_lo;
  // advance one half and compare, within the same memory cycle
  wire [W-1:0]  z_adv = cur_incu ? {z_up + 15'h0001, z_lo}
                                 : {z_up, z_lo + 15'h0001};
  wire          cw_match = z_adv[W-1:HW] == z_adv[HW-1:0];
  wire          in_move  = (state == IOPT_MOVE) & ~cur_out;
  wire          out_move = (state == IOPT_MOVE) & cur_out;
  wire          term_hit = (state == IOPT_MOVE) & cw_match;
  wire [CH_N-1:0] cur_hot = CH_N'(1) << cur_ch;
  wire [W-1:0]  in_word = in_dat_s[cur_ch*W +: W];

  // memory port: program in idle, data word in move, control word back
  wire          prog_go = idle & prog_en;
  wire          wb      = (state == IOPT_RESTORE) & (cyc == CYC_WB);
  wire          mem_we  = (prog_go & prog_we) | in_move | wb;
  wire [HW-1:0] mem_wa  = prog_go ? prog_addr : (in_move ? data_addr : cw_addr);
  wire [W-1:0]  mem_wd  = prog_go ? prog_wdata : (in_move ? in_word : z);
  wire [HW-1:0] mem_ra  = prog_go ? prog_addr
                        : ((state == IOPT_FETCH) ? cw_addr : data_addr);
  wire [W-1:0]  mem_rd  = mem[mem_ra];

  // start requests: busy test first, out of range counts as refused
  wire [CH_N-1:0] st_hot  = CH_N'(1) << start_ch;
  wire            st_bad  = start_ch >= CHW'(CH_N);
  wire            st_busy = start_out ? |(out_busy & st_hot) : |(in_busy & st_hot);
  wire            st_take = start_en & ~st_bad & ~st_busy;
  wire [CH_N-1:0] st_in   = (st_take & ~start_out) ? st_hot : CH_NONE;
  wire [CH_N-1:0] st_out  = (st_take & start_out) ? st_hot : CH_NONE;
  wire [CH_N-1:0] end_in  = (term_hit & ~cur_out) ? cur_hot : CH_NONE;
  wire [CH_N-1:0] end_out = (term_hit & cur_out) ? cur_hot : CH_NONE;

  // buffer head goes to the register that serves its channel
  wire [CHW-1:0]  f_ch     = f_head[FIFO_W-1:W];
  wire [W-1:0]    f_word   = f_head[W-1:0];
  wire            f_peer   = f_ch < CHW'(PEER_N);
  wire            peer_bsy = |out_ack[PEER_N-1:0];
  wire            gen_bsy  = |out_ack[CH_N-1:PEER_N];
  assign f_ready = f_peer ? ~peer_bsy : ~gen_bsy;
  wire            pop      = f_valid & f_ready;
  wire [CH_N-1:0] pop_hot  = pop ? (CH_N'(1) << f_ch) : CH_NONE;

  // flag updates: a set in the same cycle as a clear wins
  wire [CH_N-1:0] clr_hot = int_clr ? (CH_N'(1) << int_clr_ch) : CH_NONE;
  wire [CH_N-1:0] next_in_term  = (in_term & ~(int_clr_out ? CH_NONE : clr_hot))
                                | (end_in & in_mon);
  wire [CH_N-1:0] next_out_term = (out_term & ~(int_clr_out ? clr_hot : CH_NONE))
                                | (end_out & out_mon);
  wire [CH_N-1:0] next_in_ack  = (in_ack & in_req_s) | (in_move ? cur_hot : CH_NONE);
  wire [CH_N-1:0] next_out_ack = (out_ack & out_req_s) | pop_hot;
  wire [CH_N-1:0] next_pend    = (out_pend & ~(out_ack & ~out_req_s))
                               | ((go & ~go_in) ? out_gnt : CH_NONE);

  // output words pass through the buffer on their way to the drivers
  iopt_fifo #(.WIDTH(FIFO_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .core_clk  (core_clk),
    .resetn    (resetn),
    .in_valid  (out_move),
    .in_ready  (f_in_ready),
    .in_data   ({cur_ch, mem_rd}),
    .out_valid (f_valid),
    .out_ready (f_ready),
    .out_data  (f_head)
  );

  // memory array writes; no reset on the store itself
  always_ff @(posedge core_clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // memory cycle: fetch control word, move data, restore to full length
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      state   <= IOPT_IDLE;
      cyc     <= CYC_FIRST;
      cur_ch  <= '0;
      cur_out <= 1'b0;
      z       <= '0;
    end else begin
      case (state)
        IOPT_IDLE: begin
          cyc <= CYC_FIRST;
          if (go) begin
            state   <= IOPT_FETCH;
            cur_ch  <= go_ch;
            cur_out <= ~go_in;
          end
        end
        IOPT_FETCH: begin
          cyc   <= cyc + 7'h01;
          z     <= mem_rd;
          state <= IOPT_MOVE;
        end
        IOPT_MOVE: begin
          cyc   <= cyc + 7'h01;
          z     <= z_adv;
          state <= IOPT_RESTORE;
        end
        IOPT_RESTORE: begin
          cyc <= cyc + 7'h01;
          if (cyc == CYC_LAST) begin
            state <= IOPT_IDLE;
          end
        end
        default: state <= IOPT_IDLE;
      endcase
    end
  end

  // channel state, handshakes and status
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      in_busy       <= '0;
      out_busy      <= '0;
      in_mon        <= '0;
      out_mon       <= '0;
      in_incu       <= '0;
      out_incu      <= '0;
      in_ack        <= '0;
      out_ack       <= '0;
      out_pend      <= '0;
      in_term       <= '0;
      out_term      <= '0;
      start_ok      <= 1'b0;
      start_refused <= 1'b0;
    end else begin
      in_busy       <= (in_busy & ~end_in) | st_in;
      out_busy      <= (out_busy & ~end_out) | st_out;
      in_mon        <= (in_mon & ~st_in) | (st_in & {CH_N{start_mon}});
      out_mon       <= (out_mon & ~st_out) | (st_out & {CH_N{start_mon}});
      in_incu       <= (in_incu & ~st_in) | (st_in & {CH_N{start_inc_up}});
      out_incu      <= (out_incu & ~st_out) | (st_out & {CH_N{start_inc_up}});
      in_ack        <= next_in_ack;
      out_ack       <= next_out_ack;
      out_pend      <= next_pend;
      in_term       <= next_in_term;
      out_term      <= next_out_term;
      start_ok      <= st_take;
      start_refused <= start_en & ~st_take;
    end
  end

  // output registers; the far end's own gate picks which channel listens
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      peer_drv <= '0;
    end else if (pop & f_peer) begin
      peer_drv <= f_word;
    end
  end
  genvar g;
  generate
    for (g = 0; g < GRP_N; g++) begin : g_grp
      // one driver group per four channels, all carry the same word
      always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
          gen_drv[g*W +: W] <= '0;
        end else if (pop & ~f_peer) begin
          gen_drv[g*W +: W] <= f_word;
        end
      end
    end
  endgenerate

  // program access and interrupt summary; inputs ranked above outputs
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      prog_rdata <= '0;
      prog_done  <= 1'b0;
      int_req    <= 1'b0;
      int_out    <= 1'b0;
      int_ch     <= '0;
    end else begin
      prog_done <= prog_go;
      if (prog_go) begin
        prog_rdata <= mem_rd;
      end
      int_req <= ti_any | to_any;
      int_out <= ~ti_any & to_any;
      int_ch  <= ti_any ? ti_idx : to_idx;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  property p_one_grant;
    go |-> $onehot(go_in ? in_gnt : out_gnt) && (go_in || f_in_ready);
  endproperty
  a_one_grant: assert property (p_one_grant) else $error("grant not single");

  property p_out_high;
    go && !go_in |-> (out_elig >> out_idx) == 14'h0001;
  endproperty
  a_out_high: assert property (p_out_high) else $error("output not highest");

  property p_in_high;
    go && go_in |-> (in_elig >> in_idx) == 14'h0001 ##1 cur_ch == $past(in_idx);
  endproperty
  a_in_high: assert property (p_in_high) else $error("input not highest");

  property p_cycle_len;
    state == IOPT_FETCH |-> ##79 state == IOPT_RESTORE ##1 state == IOPT_IDLE;
  endproperty
  a_cycle_len: assert property (p_cycle_len) else $error("memory cycle length wrong");

  property p_busy_refuse;
    start_en && st_busy |=> start_refused && !start_ok;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("busy start not refused");

  property p_end_chan;
    term_hit && !cur_out |=> !in_busy[cur_ch] && state == IOPT_RESTORE;
  endproperty
  a_end_chan: assert property (p_end_chan) else $error("channel left active");

  property p_advance;
    state == IOPT_MOVE && !cur_incu |=> z[HW-1:0] == $past(z[HW-1:0]) + 15'h0001;
  endproperty
  a_advance: assert property (p_advance) else $error("control word not advanced");

  property p_in_direct;
    in_move |-> mem_we && mem_wd == in_word && mem_wa == data_addr ##1 in_ack[cur_ch];
  endproperty
  a_in_direct: assert property (p_in_direct) else $error("input word not stored");

  property p_gen_load;
    pop && !f_peer |=> gen_drv[W-1:0] == $past(f_word) && out_ack[$past(f_ch)];
  endproperty
  a_gen_load: assert property (p_gen_load) else $error("general register not loaded");

  property p_int_raise;
    term_hit && cur_mon |-> ##2 int_req;
  endproperty
  a_int_raise: assert property (p_int_raise) else $error("interrupt not raised");

  c_in_word:  cover property (in_move ##1 in_ack != CH_NONE);
  c_out_word: cover property (out_move ##[1:20] pop);
  c_term:     cover property (term_hit && cur_mon);
  c_refuse:   cover property (start_refused);
endmodule // iopt_core

// ===== sim/iopt_dev_model.sv
// iopt_dev_model: attached equipment on all input and output channels, four-phase per word
// assumes core_clk of the channel block; the bench hands out words through queue_in and queue_out
`timescale 1ns/100ps
module iopt_dev_model
  import iopt_pkg::*;
(
  input  wire logic               core_clk,
  input  wire logic               stall,
  input  wire logic [3:0]         lag,
  output logic      [CH_N-1:0]    in_req,
  output logic      [CH_N*W-1:0]  in_data,
  input  wire logic [CH_N-1:0]    in_ack,
  output logic      [CH_N-1:0]    out_req,
  input  wire logic [CH_N-1:0]    out_ack,
  input  wire logic [GRP_N*W-1:0] gen_drv,
  input  wire logic [W-1:0]       peer_drv,
  output logic                    got_v,
  output logic      [CHW-1:0]     got_ch,
  output logic      [W-1:0]       got_word
);
  int           n_in [CH_N] = '{default: 0};
  int           n_out [CH_N] = '{default: 0};
  int           hold [2*CH_N] = '{default: 0};
  logic [W-1:0] next_word [CH_N];

  initial begin
    in_req = '0;
    in_data = '0;
    out_req = '0;
    got_v = 1'b0;
  end

  task automatic queue_in(input int c, input int n, input logic [W-1:0] first);
    n_in[c] = n;
    next_word[c] = first;
  endtask

  task automatic queue_out(input int c, input int n);
    n_out[c] = n;
  endtask

  // each channel steps once a cycle; lag makes a slow device wait before asking again
  always @(negedge core_clk) begin
    got_v = 1'b0;
    for (int c = 0; c < CH_N; c++) begin
      if (hold[c] > 0)
        hold[c]--;
      else if (!in_req[c] && !in_ack[c] && n_in[c] > 0) begin
        in_req[c] = 1'b1;
        in_data[c*W +: W] = next_word[c];
      end else if (in_req[c] && in_ack[c]) begin
        in_req[c] = 1'b0;
        in_data[c*W +: W] = ~next_word[c];  // released lines never keep the old word
        next_word[c]++;
        n_in[c]--;
        hold[c] = lag;
      end
      if (hold[CH_N+c] > 0)
        hold[CH_N+c]--;
      else if (!out_req[c] && !out_ack[c] && n_out[c] > 0)
        out_req[c] = 1'b1;
      else if (out_req[c] && out_ack[c] && !stall) begin
        out_req[c] = 1'b0;
        got_v = 1'b1;
        got_ch = CHW'(c);
        got_word = (c < PEER_N) ? peer_drv : gen_drv[((c - PEER_N) / GRP_CH) * W +: W];
        n_out[c]--;
        hold[CH_N+c] = lag;
      end
    end
  end
endmodule  // iopt_dev_model

// ===== sim/io_channel_priority_transfer_tb.sv
// io_channel_priority_transfer_tb: self-checking bench for the channel core, buffer reached through it
// assumes iopt_dev_model stands for the equipment; core memory starts unknown
`timescale 1ns/100ps
module io_channel_priority_transfer_tb
  import iopt_pkg::*;
;
  logic                core_clk = 1'b0, resetn = 1'b0, start_en = 1'b0, start_out = 1'b0, start_mon = 1'b0;
  logic                start_inc_up = 1'b0, prog_en = 1'b0, prog_we = 1'b0, int_clr = 1'b0, int_clr_out = 1'b0;
  logic                start_ok, start_refused, prog_done, int_req, int_out, got_v, stall = 1'b0;
  logic [CHW-1:0]      start_ch = '0, int_clr_ch = '0, int_ch, got_ch;
  logic [CH_N-1:0]     in_req, in_ack, out_req, out_ack, in_busy, out_busy, ack_prev;
  logic [CH_N*W-1:0]   in_data;
  logic [GRP_N*W-1:0]  gen_drv;
  logic [HW-1:0]       prog_addr = '0, a;
  logic [W-1:0]        prog_wdata = '0, prog_rdata, peer_drv, got_word, base;
  logic [W:0]          e;
  logic [3:0]          lag = 4'h0;
  logic [31:0]         rnd = 32'h2CE6;
  logic [W:0]          q_rd [$];
  logic [1:0]          q_st [$];
  logic [CHW+W-1:0]    q_out [$];
  int                  q_ack [$];
  int                  order [4] = '{9, 3, 2, 1};
  int                  n_fail = 0;
  int                  compares = 0;
  int                  k;

  always #(CLK_NS/2) core_clk = ~core_clk;

  iopt_core iopt_core_i (.core_clk(core_clk), .resetn(resetn), .in_req(in_req), .in_data(in_data), .in_ack(in_ack),
    .out_req(out_req), .out_ack(out_ack), .gen_drv(gen_drv), .peer_drv(peer_drv), .start_en(start_en),
    .start_out(start_out), .start_ch(start_ch), .start_mon(start_mon), .start_inc_up(start_inc_up),
    .start_ok(start_ok), .start_refused(start_refused), .in_busy(in_busy), .out_busy(out_busy), .prog_en(prog_en),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_wdata(prog_wdata), .prog_rdata(prog_rdata),
    .prog_done(prog_done), .int_req(int_req), .int_out(int_out), .int_ch(int_ch), .int_clr(int_clr),
    .int_clr_out(int_clr_out), .int_clr_ch(int_clr_ch));
  iopt_dev_model iopt_dev_model_i (.core_clk(core_clk), .lag(lag), .in_req(in_req), .in_data(in_data),
    .in_ack(in_ack), .out_req(out_req), .out_ack(out_ack), .gen_drv(gen_drv), .peer_drv(peer_drv),
    .got_v(got_v), .got_ch(got_ch), .got_word(got_word), .stall(stall));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h00000000);
  endfunction

  task automatic check(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    compares++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic fail_out();
    n_fail++;
    report_and_stop();
  endtask

  // one program access; prog_en held until the core answers
  task automatic mem(input logic we, input logic [HW-1:0] ad, input logic [W-1:0] d, input logic chk,
                     input logic [W-1:0] exp);
    int i;
    q_rd.push_back({chk, exp});
    prog_en = 1'b1;
    prog_we = we;
    prog_addr = ad;
    prog_wdata = d;
    for (i = 0; i < 200; i++) begin
      @(negedge core_clk);
      if (prog_done === 1'b1) break;
    end
    prog_en = 1'b0;
    if (i >= 200) fail_out();
    @(negedge core_clk);
  endtask

  task automatic start(input logic o, input logic [CHW-1:0] ch, input logic mon, input logic up, input logic ok);
    q_st.push_back({ok, !ok});
    start_en = 1'b1;
    start_out = o;
    start_ch = ch;
    start_mon = mon;
    start_inc_up = up;
    @(negedge core_clk);
    start_en = 1'b0;
    repeat (2) @(negedge core_clk);
  endtask

  // waits for every channel to finish and every noted input acknowledge and output word to be seen
  task automatic wait_idle();
    int i;
    for (i = 0; i < 3000; i++) begin
      @(negedge core_clk);
      if (in_busy === '0 && out_busy === '0 && q_ack.size() == 0 && q_out.size() == 0) break;
    end
    if (i >= 3000) fail_out();
    repeat (2) @(negedge core_clk);
  endtask

  // result watcher: values sampled before the edge updates land
  always @(posedge core_clk) begin
    if (prog_done === 1'b1) begin
      e = q_rd.pop_front();
      if (e[W]) check("prog_rdata", prog_rdata, e[W-1:0]);
    end
    if (start_ok === 1'b1 || start_refused === 1'b1) check("start_ok", {start_ok, start_refused}, q_st.pop_front());
    for (int c = 0; c < CH_N; c++)
      if (in_ack[c] === 1'b1 && ack_prev[c] !== 1'b1) check("in_ack_ch", c, q_ack.pop_front());
    ack_prev = in_ack;
    if (got_v === 1'b1) check("out_word", {got_ch, got_word}, q_out.pop_front());
  end

  initial begin
    repeat (100000) @(posedge core_clk);
    fail_out();
  end

  initial begin
    repeat (4) @(negedge core_clk);
    check("reset_out", {start_ok, prog_done, int_req, in_ack, out_ack, in_busy, out_busy}, 0);
    resetn = 1'b1;
    repeat (3) @(negedge core_clk);
    // two inputs at once: 7 monitored with lower half counting, 5 with upper half counting
    mem(1'b1, CW_IN_BASE + 15'h0007, {15'h0103, 15'h0100}, 1'b0, '0);
    mem(1'b1, CW_IN_BASE + 15'h0005, {15'h0200, 15'h0201}, 1'b0, '0);
    start(1'b0, 4'h7, 1'b1, 1'b0, 1'b1);
    start(1'b0, 4'h5, 1'b0, 1'b1, 1'b1);
    start(1'b0, 4'h7, 1'b0, 1'b0, 1'b0);
    start(1'b1, 4'hE, 1'b0, 1'b0, 1'b0);
    rnd = lfsr(rnd);
    base = rnd[W-1:0];
    q_ack = '{7, 7, 7, 5};
    iopt_dev_model_i.queue_in(7, 3, base);
    iopt_dev_model_i.queue_in(5, 1, ~base);
    wait_idle();
    check("int_pending", {int_req, int_out, int_ch}, {1'b1, 1'b0, 4'h7});
    for (k = 0; k < 3; k++)
      mem(1'b0, 15'h0100 + 15'(k), '0, 1'b1, base + 30'(k));
    mem(1'b0, 15'h0100, '0, 1'b1, base);
    mem(1'b0, 15'h0200, '0, 1'b1, ~base);
    mem(1'b0, CW_IN_BASE + 15'h0007, '0, 1'b1, {15'h0103, 15'h0103});
    mem(1'b0, CW_IN_BASE + 15'h0005, '0, 1'b1, {15'h0201, 15'h0201});
    int_clr_ch = 4'h7;
    int_clr = 1'b1;
    @(negedge core_clk);
    int_clr = 1'b0;
    repeat (2) @(negedge core_clk);
    check("int_cleared", int_req, 1'b0);
    // four outputs ask together from slow equipment; peer channel 1 comes last
    lag = 4'h7;
    foreach (order[i]) begin
      a = 15'h0300 + 15'(order[i] * 4);
      rnd = lfsr(rnd);
      mem(1'b1, a, rnd[W-1:0], 1'b0, '0);
      mem(1'b1, CW_OUT_BASE + 15'(order[i]), {a + 15'h0001, a}, 1'b0, '0);
      start(1'b1, 4'(order[i]), 1'b0, 1'b0, 1'b1);
      q_out.push_back({4'(order[i]), rnd[W-1:0]});
    end
    foreach (order[i])
      iopt_dev_model_i.queue_out(order[i], 1);
    wait_idle();
    mem(1'b0, CW_OUT_BASE + 15'h0009, '0, 1'b1, {15'h0325, 15'h0325});
    // outputs 13 down to 4, first word held at the far end: the buffer takes the next
    // eight words, so channel 4 must wait for room until the stall ends
    stall = 1'b1;
    for (k = 13; k > 3; k--) begin
      a = 15'h0400 + 15'(k * 4);
      rnd = lfsr(rnd);
      mem(1'b1, a, rnd[W-1:0], 1'b0, '0);
      mem(1'b1, CW_OUT_BASE + 15'(k), {a + 15'h0001, a}, 1'b0, '0);
      start(1'b1, 4'(k), 1'b0, 1'b0, 1'b1);
      q_out.push_back({4'(k), rnd[W-1:0]});
    end
    for (k = 13; k > 3; k--)
      iopt_dev_model_i.queue_out(k, 1);
    repeat (1000) @(negedge core_clk);
    check("fifo_fill", out_busy, 14'h0010);
    check("fifo_data", {out_ack, gen_drv[W-1:0]}, {14'h2000, q_out[0][W-1:0]});
    stall = 1'b0;
    wait_idle();
    check("fifo_drain", {out_busy, out_ack}, 0);
    report_and_stop();
  end
endmodule  // io_channel_priority_transfer_tb
